// [design/sds_pkg.sv]
// Package of the suppression discharge sequencer: register map, field positions,
// reset values, timing figures, state encodings and carrier structs.
// Assumes a single 25 MHz system clock and an APB register port with 32-bit data.
package sds_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;
  localparam int WARN_S = 5;
  localparam int SHORT_DELAY_S = 5;
  localparam int LONG_DELAY_S = 10;
  localparam int BREAK_MIN_S = 1;
  // One tick more than the minimum: the first tick may land anywhere in the first second
  localparam int BREAK_TICKS = BREAK_MIN_S + 1;
  localparam int POR_WAIT_CYCLES = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FAULT = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;

  // STATUS fields
  localparam int ST_GEN1 = 0;
  localparam int ST_GEN2 = 1;
  localparam int ST_WARN = 2;
  localparam int ST_SOUNDER = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_WARN_ALARM = 5;
  localparam int ST_CONFIRMED = 6;
  localparam int ST_TEST = 7;
  localparam int ST_LOOP1_FLT = 8;
  localparam int ST_LOOP2_FLT = 9;
  localparam int ST_REMOTE_FLT = 10;
  localparam int ST_RESET_SEEN = 11;
  localparam int ST_MODE_LSB = 12;

  // FAULT fields (sticky, write one to clear)
  localparam int FL_GEN1_BRK = 0;
  localparam int FL_GEN2_BRK = 1;
  localparam int FL_UNDER = 2;
  localparam int FL_OVER = 3;
  localparam int FL_LAMP_LSB = 4;

  // CONFIG fields
  localparam int CF_LONG_DELAY = 0;
  localparam int CF_LOOP1_CONFIRM = 1;

  // Lamp indices
  localparam int LAMP_POWER = 0;
  localparam int LAMP_FAULT = 1;
  localparam int LAMP_ALARM = 2;
  localparam int LAMP_ACT = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LOOP_SHORT = 3'b000,
    LOOP_CLOSED = 3'b001,
    LOOP_OPEN = 3'b010,
    LOOP_FREE = 3'b011,
    LOOP_ERROR = 3'b100
  } sds_loop_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WARN = 2'b01,
    SEQ_FIRED = 2'b10
  } sds_seq_e;

  typedef enum logic [2:0] {
    MODE_START = 3'b000,
    MODE_LAMPCHK = 3'b001,
    MODE_ST1 = 3'b010,
    MODE_ST2 = 3'b011,
    MODE_ST3 = 3'b100,
    MODE_NORMAL = 3'b101
  } sds_mode_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic long_delay;
    logic loop1_confirm;
  } sds_cfg_s;

  typedef struct packed {
    logic [3:0] lamp;
    logic over;
    logic under;
    logic gen2_brk;
    logic gen1_brk;
  } sds_fault_s;

endpackage : sds_pkg

// [design/sds_sequencer.sv]
// Discharge sequencer of a suppression control panel: manual and remote discharge,
// loop and generator fault handling, lamp reserve switching, power-on test stage 1.
// Assumes loop states arrive already classified on pclk; buttons and senses are raw pins.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module sds_sequencer #(
  parameter int TICK_CYCLES = sds_pkg::TICK_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_left,
  input wire logic btn_right,
  input wire logic silence_btn,
  input wire logic reset_btn,
  input wire logic gen1_break,
  input wire logic gen2_break,
  input wire logic cur_under,
  input wire logic cur_over,
  input wire logic [3:0] lamp_fail,
  input wire logic [7:0] config_switch,
  input wire logic cfg_long_delay,
  input wire logic cfg_loop1_confirm,
  input wire sds_pkg::sds_loop_e loop1_state,
  input wire sds_pkg::sds_loop_e loop2_state,
  input wire sds_pkg::sds_loop_e remote_state,
  output logic sounder,
  output logic out1,
  output logic gen1_fire,
  output logic gen2_fire,
  output logic confirmed,
  output logic [3:0] lamp_main,
  output logic [3:0] lamp_reserve
);

  // ----------------------------------------------------------------
  // Pin filtering
  // ----------------------------------------------------------------
  localparam int NPIN = 22;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin;
  assign pin_raw = {cfg_loop1_confirm, cfg_long_delay, config_switch, lamp_fail, cur_over,
                    cur_under, gen2_break, gen1_break, reset_btn, silence_btn, btn_right,
                    btn_left};

  // A level is taken only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= (sync2 & sync3) | (pin & (sync2 | sync3));
    end
  end

  logic f_left;
  logic f_right;
  logic f_silence;
  logic f_reset;
  logic f_gen1_brk;
  logic f_gen2_brk;
  logic f_under;
  logic f_over;
  logic [3:0] f_lamp_fail;
  logic [7:0] f_sw;
  sds_pkg::sds_cfg_s f_cfg;
  assign f_left = pin[0];
  assign f_right = pin[1];
  assign f_silence = pin[2];
  assign f_reset = pin[3];
  assign f_gen1_brk = pin[4];
  assign f_gen2_brk = pin[5];
  assign f_under = pin[6];
  assign f_over = pin[7];
  assign f_lamp_fail = pin[11:8];
  assign f_sw = pin[19:12];
  assign f_cfg = pin[21:20];

  logic silence_d;
  logic reset_d;
  logic silence_press;
  logic reset_press;
  assign silence_press = f_silence & ~silence_d;
  assign reset_press = f_reset & ~reset_d;

  // ----------------------------------------------------------------
  // Second tick and blink phase
  // ----------------------------------------------------------------
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [PW-1:0] PRESC_HALF = PW'(TICK_CYCLES / 2);
  logic [PW-1:0] presc;
  logic tick;
  logic blink;
  logic presc_wrap;
  assign presc_wrap = (presc == PRESC_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
      tick <= 1'b0;
      blink <= 1'b0;
      silence_d <= 1'b0;
      reset_d <= 1'b0;
    end else begin
      presc <= presc_wrap ? '0 : presc + 1'b1;
      tick <= presc_wrap;
      blink <= (presc == PRESC_HALF) || presc_wrap ? ~blink : blink;
      silence_d <= f_silence;
      reset_d <= f_reset;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode and test stages
  // ----------------------------------------------------------------
  sds_pkg::sds_mode_e mode;
  sds_pkg::sds_mode_e next_mode;
  logic [2:0] por_cnt;
  sds_pkg::sds_cfg_s cfg;
  logic reset_seen;
  logic normal;
  assign normal = (mode == sds_pkg::MODE_NORMAL);

  always_comb begin
    next_mode = mode;
    unique case (mode)
      sds_pkg::MODE_START: begin
        if (por_cnt == 3'(sds_pkg::POR_WAIT_CYCLES)) begin
          next_mode = f_silence ? sds_pkg::MODE_LAMPCHK : sds_pkg::MODE_NORMAL;
        end
      end
      sds_pkg::MODE_LAMPCHK: begin
        if (!f_silence) begin
          next_mode = sds_pkg::MODE_ST1;
        end
      end
      sds_pkg::MODE_ST1: begin
        if (reset_press) begin
          next_mode = sds_pkg::MODE_ST2;
        end
      end
      sds_pkg::MODE_ST2: begin
        if (reset_press) begin
          next_mode = sds_pkg::MODE_ST3;
        end
      end
      sds_pkg::MODE_ST3: begin
        if (reset_press) begin
          next_mode = sds_pkg::MODE_NORMAL;
        end
      end
      sds_pkg::MODE_NORMAL: begin
        next_mode = sds_pkg::MODE_NORMAL;
      end
      default: begin
        next_mode = sds_pkg::MODE_START;
      end
    endcase
  end

  // Straps are caught once the filters have settled, never by the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= sds_pkg::MODE_START;
      por_cnt <= '0;
      cfg <= '0;
      reset_seen <= 1'b0;
    end else begin
      mode <= next_mode;
      if (mode == sds_pkg::MODE_START) begin
        por_cnt <= por_cnt + 1'b1;
        cfg <= f_cfg;
      end
      if (reset_press && !normal) begin
        reset_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop classification
  // ----------------------------------------------------------------
  logic loop1_alarm;
  logic loop1_fault;
  logic loop2_alarm;
  logic loop2_fault;
  logic remote_alarm;
  logic remote_fault;
  assign loop1_alarm = (loop1_state == sds_pkg::LOOP_SHORT);
  assign loop1_fault = !loop1_alarm && (loop1_state != sds_pkg::LOOP_CLOSED);
  assign loop2_alarm = (loop2_state == sds_pkg::LOOP_OPEN);
  assign loop2_fault = !loop2_alarm && (loop2_state != sds_pkg::LOOP_CLOSED);
  assign remote_alarm = (remote_state == sds_pkg::LOOP_OPEN);
  assign remote_fault = !remote_alarm && (remote_state != sds_pkg::LOOP_CLOSED);

  // Loop 1 and 2 alarms never start a discharge; in confirm use loop 1 reports the firing
  logic warn_alarm;
  assign warn_alarm = normal && ((loop1_alarm && !cfg.loop1_confirm) || loop2_alarm);
  // (loop 2 term above)

  // ----------------------------------------------------------------
  // Discharge sequence
  // ----------------------------------------------------------------
  sds_pkg::sds_seq_e seq;
  sds_pkg::sds_seq_e next_seq;
  logic [3:0] warn_cnt;
  logic [3:0] sec_cnt;
  logic both_held;
  logic warn_done;
  logic sec_due;
  logic [3:0] sec_delay;
  assign both_held = f_left & f_right;
  assign warn_done = (warn_cnt == 4'(sds_pkg::WARN_S));
  assign sec_delay = cfg.long_delay ? 4'(sds_pkg::LONG_DELAY_S) : 4'(sds_pkg::SHORT_DELAY_S);
  assign sec_due = (sec_cnt == sec_delay);

  always_comb begin
    next_seq = seq;
    unique case (seq)
      sds_pkg::SEQ_IDLE: begin
        if (normal && remote_alarm) begin
          next_seq = sds_pkg::SEQ_FIRED;
        end else if (normal && both_held) begin
          next_seq = sds_pkg::SEQ_WARN;
        end
      end
      sds_pkg::SEQ_WARN: begin
        if (remote_alarm) begin
          next_seq = sds_pkg::SEQ_FIRED;
        end else if (!both_held) begin
          next_seq = sds_pkg::SEQ_IDLE;
        end else if (warn_done) begin
          next_seq = sds_pkg::SEQ_FIRED;
        end
      end
      sds_pkg::SEQ_FIRED: begin
        if (reset_press) begin
          next_seq = sds_pkg::SEQ_IDLE;
        end
      end
      default: begin
        next_seq = sds_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= sds_pkg::SEQ_IDLE;
      warn_cnt <= '0;
      sec_cnt <= '0;
    end else begin
      seq <= next_seq;
      warn_cnt <= (next_seq != sds_pkg::SEQ_WARN) ? '0 :
                  (tick ? warn_cnt + 1'b1 : warn_cnt);
      sec_cnt <= (next_seq != sds_pkg::SEQ_FIRED) ? '0 :
                 ((tick && !sec_due) ? sec_cnt + 1'b1 : sec_cnt);
    end
  end

  // ----------------------------------------------------------------
  // Faults
  // ----------------------------------------------------------------
  logic [1:0] brk1_cnt;
  logic [1:0] brk2_cnt;
  sds_pkg::sds_fault_s fault;
  sds_pkg::sds_fault_s fault_set;
  sds_pkg::sds_fault_s fault_clr;
  logic [3:0] lamp_ack;
  logic apb_wr;
  logic [31:0] apb_rdata;
  logic apb_hit;
  assign apb_wr = psel & penable & pready & pwrite;

  assign fault_set.gen1_brk = (brk1_cnt == 2'(sds_pkg::BREAK_TICKS));
  assign fault_set.gen2_brk = (brk2_cnt == 2'(sds_pkg::BREAK_TICKS));
  assign fault_set.under = gen1_fire & f_under;
  assign fault_set.over = gen1_fire & f_over;
  assign fault_set.lamp = f_lamp_fail & {4{normal}};
  assign fault_clr = (apb_wr && paddr == sds_pkg::ADDR_FAULT) ? pwdata[7:0] : '0;

  logic any_fault;
  logic lamp_pending;
  // Current faults count alike whether or not the discharge was confirmed
  assign any_fault = normal && (loop1_fault || loop2_fault || remote_fault ||
                     fault.gen1_brk || fault.gen2_brk || fault.under || fault.over);
  assign lamp_pending = |(fault.lamp & ~lamp_ack);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk1_cnt <= '0;
      brk2_cnt <= '0;
      fault <= sds_pkg::FAULT_RESET[7:0];
      lamp_ack <= '0;
    end else begin
      // Short breaks restart the count and are forgotten
      brk1_cnt <= !f_gen1_brk ? '0 : ((tick && !fault_set.gen1_brk) ? brk1_cnt + 1'b1 : brk1_cnt);
      brk2_cnt <= !f_gen2_brk ? '0 : ((tick && !fault_set.gen2_brk) ? brk2_cnt + 1'b1 : brk2_cnt);
      fault <= fault_set | (fault & ~fault_clr);
      // Acknowledge covers only failures present at the press; a cleared lamp drops its ack
      lamp_ack <= (silence_press && normal) ? (lamp_ack | fault.lamp) : (lamp_ack & fault.lamp);
    end
  end

  // ----------------------------------------------------------------
  // Lamps and outputs
  // ----------------------------------------------------------------
  logic [3:0] lamp_on;
  logic [3:0] st1_on;
  logic [3:0] next_main;
  logic [3:0] next_reserve;
  assign lamp_on[sds_pkg::LAMP_POWER] = 1'b1;
  assign lamp_on[sds_pkg::LAMP_FAULT] = any_fault | (lamp_pending & blink);
  assign lamp_on[sds_pkg::LAMP_ALARM] = warn_alarm | (seq != sds_pkg::SEQ_IDLE);
  assign lamp_on[sds_pkg::LAMP_ACT] = (seq == sds_pkg::SEQ_FIRED);
  assign st1_on[sds_pkg::LAMP_POWER] = f_sw[0] | f_sw[4] | f_sw[6];
  assign st1_on[sds_pkg::LAMP_FAULT] = f_sw[1] | f_sw[4] | f_sw[7];
  assign st1_on[sds_pkg::LAMP_ALARM] = f_sw[2] | f_sw[5] | f_sw[6];
  assign st1_on[sds_pkg::LAMP_ACT] = f_sw[3] | f_sw[5] | f_sw[7];

  always_comb begin
    next_main = '0;
    next_reserve = '0;
    unique case (mode)
      sds_pkg::MODE_LAMPCHK: begin
        next_main = {4{blink}};
        next_reserve = {4{~blink}};
      end
      sds_pkg::MODE_ST1: begin
        next_main = st1_on & {4{blink}};
        next_reserve = st1_on & {4{~blink}};
      end
      sds_pkg::MODE_NORMAL: begin
        next_main = lamp_on & ~fault.lamp;
        next_reserve = lamp_on & fault.lamp;
      end
      default: begin
        next_main = '0;
        next_reserve = '0;
      end
    endcase
  end

  logic next_sounder;
  logic fired;
  assign fired = (seq == sds_pkg::SEQ_FIRED);
  // Continuous tone wins over the intermittent one
  assign next_sounder = normal && (any_fault || fired ||
                        (blink && (seq == sds_pkg::SEQ_WARN || warn_alarm)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sounder <= 1'b0;
      out1 <= 1'b0;
      gen1_fire <= 1'b0;
      gen2_fire <= 1'b0;
      confirmed <= 1'b0;
      lamp_main <= '0;
      lamp_reserve <= '0;
    end else begin
      sounder <= next_sounder;
      out1 <= any_fault;
      gen1_fire <= fired;
      gen2_fire <= fired && sec_due;
      confirmed <= fired ? (confirmed | (cfg.loop1_confirm & loop1_alarm)) : 1'b0;
      lamp_main <= next_main;
      lamp_reserve <= next_reserve;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  assign status_word = {17'h0, mode, reset_seen, remote_fault, loop2_fault, loop1_fault,
                        !normal, confirmed, warn_alarm, any_fault, sounder,
                        (seq == sds_pkg::SEQ_WARN), gen2_fire, gen1_fire};
  assign apb_hit = (paddr == sds_pkg::ADDR_STATUS) || (paddr == sds_pkg::ADDR_FAULT) ||
                   (paddr == sds_pkg::ADDR_CONFIG);
  assign apb_rdata = (paddr == sds_pkg::ADDR_STATUS) ? status_word :
                     (paddr == sds_pkg::ADDR_FAULT) ? {24'h0, fault} :
                     (paddr == sds_pkg::ADDR_CONFIG) ? {30'h0, cfg} : 32'h0;

  // Answer is prepared in the setup cycle, so every access phase completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel && !penable && !pwrite) ? apb_rdata : prdata;
      pslverr <= psel & ~penable & ~apb_hit;
    end
  end

endmodule : sds_sequencer

// [testbench/sds_field.sv]
// Far-side model: generator cables and the discharge current they draw.
// Assumes the bench picks the load and drives the other panel pins itself.
`timescale 1ns/1ps
module sds_field (
  input wire logic pclk,
  input wire logic gen1_fire,
  input wire logic [1:0] load,
  input wire logic cut2,
  output logic gen1_break,
  output logic gen2_break,
  output logic cur_under,
  output logic cur_over
);
  // Load 0 nominal, 1 high resistance, 2 shorted, 3 cable cut
  always_ff @(posedge pclk) begin
    gen1_break <= load == 2'h3;
    gen2_break <= cut2;
    // A cut or high-resistance load never reaches the minimum current
    cur_under <= gen1_fire && load[0];
    cur_over <= gen1_fire && load == 2'h2;
  end
endmodule : sds_field

// [testbench/sds_sva.sv]
// Port checker of the discharge sequencer, bound to the sequencer module.
// Assumes straps stay put while out of reset and no loop fault in test mode.
`timescale 1ns/1ps
module sds_sva #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic btn_left,
  input wire logic btn_right,
  input wire logic gen1_break,
  input wire logic gen2_break,
  input wire logic cur_under,
  input wire logic cur_over,
  input wire logic cfg_long_delay,
  input wire sds_pkg::sds_loop_e loop1_state,
  input wire sds_pkg::sds_loop_e loop2_state,
  input wire sds_pkg::sds_loop_e remote_state,
  input wire logic sounder,
  input wire logic out1,
  input wire logic gen1_fire,
  input wire logic gen2_fire
);
  int cyc;
  int held;
  int on;
  int brk;
  int rem;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= 0;
      held <= 0;
      on <= 0;
      brk <= 0;
      rem <= 99;
    end else begin
      cyc <= cyc + 1;
      held <= (btn_left && btn_right) ? held + 1 : 0;
      on <= gen1_fire ? on + 1 : 0;
      brk <= (gen1_break || gen2_break) ? brk + 1 : 0;
      rem <= (remote_state == sds_pkg::LOOP_OPEN) ? 0 : (rem < 99 ? rem + 1 : rem);
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_fired;
    gen1_fire [*2];
  endsequence
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (pready && paddr > 8'h08 |-> pslverr)
    else $error("no error on unmapped address");
  a_fire_cause: assert property ($rose(gen1_fire) |->
    rem < 8 || $past(held, 5) >= 4 * TICK_CYCLES - 8) else $error("primary fired without cause");
  a_tone_steady: assert property (s_fired |-> sounder)
    else $error("no steady tone after discharge");
  a_gen2_delay: assert property ($rose(gen2_fire) |->
    on >= ((cfg_long_delay ? 10 : 5) - 1) * TICK_CYCLES
    && on <= (cfg_long_delay ? 10 : 5) * TICK_CYCLES + 2) else $error("secondary delay wrong");
  a_gen2_after: assert property (gen2_fire |-> gen1_fire)
    else $error("secondary without primary");
  a_fault_tone: assert property (out1 [*2] |-> sounder)
    else $error("fault without tone");
  a_loop_fault: assert property (cyc > 16 && (loop1_state == sds_pkg::LOOP_OPEN
    || loop2_state == sds_pkg::LOOP_SHORT || remote_state == sds_pkg::LOOP_SHORT)
    |-> ##[0:3] out1) else $error("loop fault not shown");
  a_break_fault: assert property (brk == 3 * TICK_CYCLES |-> out1)
    else $error("lasting break not shown");
  a_cur_fault: assert property ((gen1_fire && (cur_under || cur_over)) [*8] |-> out1)
    else $error("current fault not shown");
endmodule : sds_sva

bind sds_sequencer sds_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .btn_left(btn_left), .btn_right(btn_right), .gen1_break(gen1_break),
  .gen2_break(gen2_break), .cur_under(cur_under), .cur_over(cur_over),
  .cfg_long_delay(cfg_long_delay), .loop1_state(loop1_state), .loop2_state(loop2_state),
  .remote_state(remote_state), .sounder(sounder), .out1(out1), .gen1_fire(gen1_fire),
  .gen2_fire(gen2_fire));

// [testbench/tb_top.sv]
// Self-checking bench of the discharge sequencer with a short seconds tick.
// Assumes the field model on the generator side; reads checked from a queue.
`timescale 1ns/1ps
module tb_top;
  localparam int T = 20;
  localparam logic [3:0] MAP [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'h5, 4'hA};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00, config_switch = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic btn_left = 0, btn_right = 0, silence_btn = 0, reset_btn = 0, cut2 = 0;
  logic cfg_long_delay = 0, cfg_loop1_confirm = 0, gen1_break, gen2_break, cur_under, cur_over;
  logic sounder, out1, gen1_fire, gen2_fire, confirmed;
  logic [3:0] lamp_fail = 4'h0, lamp_main, lamp_reserve, om, orr;
  logic [1:0] load = 2'h0;
  logic [64:0] notes [$];
  logic [64:0] e;
  sds_pkg::sds_loop_e loop1_state = sds_pkg::LOOP_CLOSED, loop2_state = sds_pkg::LOOP_CLOSED;
  sds_pkg::sds_loop_e remote_state = sds_pkg::LOOP_CLOSED;
  int error_cnt = 0, total_checks = 0, seed = 18573, cyc = 0, n, m;

  sds_sequencer #(.TICK_CYCLES(T)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .btn_left, .btn_right, .silence_btn, .reset_btn,
    .gen1_break, .gen2_break, .cur_under, .cur_over, .lamp_fail, .config_switch,
    .cfg_long_delay, .cfg_loop1_confirm, .loop1_state, .loop2_state, .remote_state, .sounder,
    .out1, .gen1_fire, .gen2_fire, .confirmed, .lamp_main, .lamp_reserve);
  sds_field u_field (.pclk, .gen1_fire, .load, .cut2, .gen1_break, .gen2_break, .cur_under,
    .cur_over);

  initial forever #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // Reads queue error flag, mask, word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] k, input logic er);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) notes.push_back({er, k, d});
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rst(input logic s, input logic l, input logic c);
    presetn <= 0;
    silence_btn <= s;
    cfg_long_delay <= l;
    cfg_loop1_confirm <= c;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (12) @(posedge pclk);
  endtask : rst
  task automatic tap;
    reset_btn <= 1;
    repeat (8) @(posedge pclk);
    reset_btn <= 0;
    repeat (8) @(posedge pclk);
  endtask : tap
  task automatic blinks(output int c);
    logic p;
    c = 0;
    p = lamp_main[1];
    repeat (2 * T) begin
      @(posedge pclk);
      c += int'(lamp_main[1] !== p);
      p = lamp_main[1];
    end
  endtask : blinks
  task automatic wait_g1;
    n = 0;
    while (gen1_fire !== 1'b1 && n < 12 * T) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_g1
  task automatic wait_g2;
    m = 0;
    while (gen2_fire !== 1'b1 && m < 12 * T) begin
      @(posedge pclk);
      m++;
    end
  endtask : wait_g2

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
    if (psel && penable && pready && !pwrite) begin
      e = notes.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[64]});
      chk(prdata & e[63:32], e[31:0]);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst(0, 0, 0);
    apb(0, 8'h08, 32'h0, 32'hFFFFFFFF, 0);
    apb(0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1);
    btn_left <= 1;
    btn_right <= 1;
    repeat (20 + {$random(seed)} % (3 * T)) @(posedge pclk);
    btn_left <= 0;
    repeat (6 * T) @(posedge pclk);
    chk(gen1_fire, 0);
    btn_left <= 1;
    repeat (20) @(posedge pclk);
    apb(0, 8'h00, 32'h4, 32'h4, 0);
    wait_g1();
    chk(n >= 4 * T - 20 && n <= 5 * T + 4, 1);
    wait_g2();
    chk(m >= 4 * T && m <= 5 * T + 2, 1);
    btn_left <= 0;
    btn_right <= 0;
    apb(0, 8'h00, 32'hB, 32'hF, 0);
    load <= 2'h1;
    repeat (12) @(posedge pclk);
    chk(out1, 1);
    load <= 2'h2;
    repeat (12) @(posedge pclk);
    apb(0, 8'h04, 32'hC, 32'hF, 0);
    load <= 2'h0;
    repeat (8) @(posedge pclk);
    apb(1, 8'h04, 32'hF, 32'h0, 0);
    apb(0, 8'h04, 32'h0, 32'hF, 0);
    tap();
    chk(gen1_fire, 0);
    load <= 2'h3;
    repeat (T / 2) @(posedge pclk);
    load <= 2'h0;
    repeat (3 * T) @(posedge pclk);
    apb(0, 8'h04, 32'h0, 32'h3, 0);
    load <= 2'h3;
    cut2 <= 1;
    repeat (3 * T) @(posedge pclk);
    load <= 2'h0;
    cut2 <= 0;
    repeat (8) @(posedge pclk);
    apb(0, 8'h04, 32'h3, 32'h3, 0);
    apb(1, 8'h04, 32'h3, 32'h0, 0);
    for (int i = 0; i < 3; i++) begin
      loop1_state <= (i == 0) ? sds_pkg::LOOP_OPEN : sds_pkg::LOOP_CLOSED;
      loop2_state <= (i == 1) ? sds_pkg::LOOP_SHORT : sds_pkg::LOOP_CLOSED;
      remote_state <= (i == 2) ? sds_pkg::LOOP_SHORT : sds_pkg::LOOP_CLOSED;
      repeat (6) @(posedge pclk);
      chk(out1, 1);
      apb(0, 8'h00, 32'h100 << i, 32'h100 << i, 0);
    end
    loop1_state <= sds_pkg::LOOP_SHORT;
    loop2_state <= sds_pkg::LOOP_OPEN;
    remote_state <= sds_pkg::LOOP_CLOSED;
    repeat (7 * T) @(posedge pclk);
    chk({out1, gen1_fire}, 0);
    apb(0, 8'h00, 32'h20, 32'h20, 0);
    loop1_state <= sds_pkg::LOOP_CLOSED;
    loop2_state <= sds_pkg::LOOP_CLOSED;
    lamp_fail <= 4'h1;
    repeat (10) @(posedge pclk);
    blinks(n);
    chk({n > 0, lamp_main[0], lamp_reserve[0]}, 3'b101);
    silence_btn <= 1;
    repeat (8) @(posedge pclk);
    silence_btn <= 0;
    repeat (10) @(posedge pclk);
    blinks(n);
    chk({n, lamp_reserve[0]}, 1);
    apb(0, 8'h04, 32'h10, 32'hF0, 0);
    rst(0, 1, 1);
    remote_state <= sds_pkg::LOOP_OPEN;
    wait_g1();
    chk(n <= 4, 1);
    remote_state <= sds_pkg::LOOP_CLOSED;
    wait_g2();
    chk(m >= 9 * T - 2 && m <= 10 * T + 2, 1);
    loop1_state <= sds_pkg::LOOP_SHORT;
    repeat (4) @(posedge pclk);
    chk(confirmed, 1);
    loop1_state <= sds_pkg::LOOP_CLOSED;
    rst(1, 0, 0);
    blinks(n);
    chk(n > 0, 1);
    silence_btn <= 0;
    repeat (10) @(posedge pclk);
    apb(0, 8'h00, 32'h2080, 32'h7080, 0);
    for (int i = 0; i < 8; i++) begin
      config_switch <= 8'h01 << i;
      repeat (8) @(posedge pclk);
      om = 4'h0;
      orr = 4'h0;
      repeat (T + 2) begin
        @(posedge pclk);
        om |= lamp_main;
        orr |= lamp_reserve;
      end
      chk({om, orr}, {MAP[i], MAP[i]});
    end
    for (int k = 3; k < 6; k++) begin
      tap();
      apb(0, 8'h00, k << 12, 32'h7000, 0);
    end
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule : tb_top
